// [inc/fmf_pkg.sv]
// package: constants, types and helpers of the modem framing core
//------------------------------------------------------------
// How it works
// (R1) tx adds two checksum bytes per six
// (R2) rx checks checksum every eight bytes
// (R3) no checksum work while sync search armed
// (R4) hold only when hold bit and wake high
// (R5) bytes go out and come in msb first
// (R6) search matches sync word and its inverse
// (R7) host loads sync msb first, pads preamble
// (R8) status bits in fixed order, top two zero
// (R9) checksum flag set, cleared by reads or tx
// (R10) sync flags cleared by status read or tx
// (R11) idle flag after last byte and hang bit
// (R12) byte wanted flag cleared by read then write
// (R13) host reads rx byte within eight bits
// (R14) interrupt only with interrupt enable set
// (R15) interrupt withdrawn on status read, direction change
// (R16) reset command zeroes control, tx to bias
// (R17) reset command keeps status, buffers, sync word; from tx mode the direction drop clears tx_idle and tx_want
// (R18) serial bus sampled on rising edge, msb first
// (R19) sync found clears both arm bits
// (R20) first byte sets tx framing; rx holds bias
// (R21) host disables checksum over preamble and sync
// (R22) hang bit of one ends transmission
// (R23) fixed command byte values
// (R24) unit select needs bit 3, except reset
// (R25) raw receive delivers bytes without sync
// (R26) bit 0 direction, bit 1 checksum enable
// (R27) open drain low interrupt while events pending
//------------------------------------------------------------
`default_nettype none
package fmf_pkg;
	//------------------------------------------------------------
	// command bytes
	//------------------------------------------------------------
	localparam logic [7:0] CMD_RESET = 8'h01;
	localparam logic [7:0] CMD_CTRL = 8'h40;
	localparam logic [7:0] CMD_STAT = 8'h41;
	localparam logic [7:0] CMD_RXRD = 8'h42;
	localparam logic [7:0] CMD_TXWR = 8'h43;
	localparam logic [7:0] CMD_SYNC = 8'h44;
	localparam int UNIT_BIT = 3;
	localparam logic [7:0] UNIT_MASK = 8'h08;
	localparam logic [1:0] LEN_ONE = 2'h1;
	localparam logic [1:0] LEN_TWO = 2'h2;
	localparam logic [1:0] LEN_MAX = 2'h3;
	//------------------------------------------------------------
	// framing and checksum
	//------------------------------------------------------------
	localparam logic [14:0] CKS_POLY = 15'h6815;
	localparam logic [2:0] CKS_GROUP = 3'h6;
	localparam logic [5:0] RX_CKS_LAST = 6'h3F;
	localparam logic [5:0] RX_CKS_INV = 6'h3E;
	localparam logic [4:0] CKS_BITS_LEFT = 5'h0F;
	localparam logic [4:0] BYTE_BITS_LEFT = 5'h07;
	localparam logic [2:0] RX_BYTE_LAST = 3'h7;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 16;
	//------------------------------------------------------------
	// reset values
	//------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] PIN_RST = 8'h42;
	//------------------------------------------------------------
	// types
	//------------------------------------------------------------
	typedef struct packed {
		logic spare7;
		logic arm_b;
		logic arm_a;
		logic spare4;
		logic irq_en;
		logic hold_en;
		logic cks_en;
		logic tx_dir;
	} fmf_ctrl_s;
	typedef struct packed {
		logic [1:0] undef;
		logic sync_hit;
		logic inv_hit;
		logic tx_idle;
		logic tx_want;
		logic cks_ok;
		logic rx_avail;
	} fmf_stat_s;
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_DATA = 4'h2,
		TX_CKS = 4'h4,
		TX_HANG = 4'h8
	} fmf_tx_e;
	function automatic logic [14:0] fmf_crc_step(input logic [14:0] c, input logic b);
		fmf_crc_step = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? CKS_POLY : 15'h0000);
	endfunction
endpackage
`default_nettype wire

// [verilog/fmf_fifo.sv]
// module: small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module fmf_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	localparam logic [AW-1:0] LAST = AW'(D-1);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	assign in_ready_o = (cnt_r != FULL);
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rp_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	// storage has no reset: contents are don't-care until written
	always_ff @(posedge clk_i)
	begin
		if (push)
			mem_r[wp_r] <= in_data_i;
	end
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule
`default_nettype wire

// [verilog/fmf_top.sv]
// module: serial control port, framer, sync detector and event flags
`timescale 1ns/1ps
`default_nettype none
module fmf_top (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// serial control bus
	input wire logic sclk_i,
	input wire logic csn_i,
	input wire logic cmd_data_i,
	output logic reply_data_o,
	output logic reply_oe_o,
	// straps and controls
	input wire logic unit_sel_i,
	input wire logic wake_i,
	input wire logic raw_rx_n_i,
	output logic hold_o,
	// interrupt, open drain
	output logic irq_n_o,
	output logic irq_oe_o,
	// bit link to the tone modem
	input wire logic link_clk_i,
	input wire logic rx_bit_i,
	output logic tx_bit_o,
	output logic tx_active_o,
	output logic tx_bias_o
);
	import fmf_pkg::*;

	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	logic [7:0] pin_s1_r;
	logic [7:0] pin_s2_r;
	logic sclk_d_r;
	logic csn_d_r;
	logic link_d_r;
	logic sclk_s;
	logic csn_s;
	logic cmd_s;
	logic link_s;
	logic rxb_s;
	logic wake_s;
	logic raw_n_s;
	logic unit_s;
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_s1_r <= PIN_RST;
			pin_s2_r <= PIN_RST;
			sclk_d_r <= 1'b0;
			csn_d_r <= 1'b1;
			link_d_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= {unit_sel_i, raw_rx_n_i, wake_i, rx_bit_i,
				link_clk_i, cmd_data_i, csn_i, sclk_i};
			pin_s2_r <= pin_s1_r;
			sclk_d_r <= sclk_s;
			csn_d_r <= csn_s;
			link_d_r <= link_s;
		end
	end
	assign {unit_s, raw_n_s, wake_s, rxb_s, link_s, cmd_s, csn_s, sclk_s} = pin_s2_r;

	//------------------------------------------------------------
	// shared state and events
	//------------------------------------------------------------
	fmf_ctrl_s ctrl_r;
	fmf_stat_s stat_r;
	fmf_tx_e tx_st_r;
	logic [7:0] rx_buf_r;
	logic [15:0] sync_r;
	logic [15:0] win_r;
	logic [15:0] win_nxt;
	logic [14:0] crc_r;
	logic par_r;
	logic hold;
	logic armed;
	logic bit_edge;
	logic rx_edge;
	logic tx_edge;
	logic ev_sync;
	logic ev_inv;
	logic ev_rx;
	logic ev_cks;
	logic ev_want;
	logic ev_idle;
	logic sclk_rise;
	logic cs_act;
	logic cs_end;
	assign hold = ctrl_r.hold_en && wake_s; // (R4)
	assign hold_o = hold;
	assign armed = ctrl_r.arm_a || ctrl_r.arm_b;
	// a held block ignores the link; the control port stays alive for wake-up
	assign bit_edge = link_s && !link_d_r && !hold; // (R4)
	assign rx_edge = bit_edge && !ctrl_r.tx_dir; // (R26)
	assign tx_edge = bit_edge && ctrl_r.tx_dir; // (R26)
	assign sclk_rise = sclk_s && !sclk_d_r; // (R18)
	assign cs_act = !csn_s;
	assign cs_end = csn_s && !csn_d_r;

	//------------------------------------------------------------
	// serial control port
	//------------------------------------------------------------
	logic [7:0] sb_sr_r;
	logic [7:0] cmd_r;
	logic [7:0] d0_r;
	logic [7:0] d1_r;
	logic [7:0] rep_sr_r;
	logic [2:0] sb_cnt_r;
	logic [1:0] sb_len_r;
	logic rep_en_r;
	logic rd_stat_r;
	logic rd_rx_r;
	logic [7:0] sb_byte;
	logic wr_reset;
	logic wr_ctrl;
	logic wr_txwr;
	logic wr_sync;
	function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] k, input logic u);
		is_cmd = (c[UNIT_BIT] == u) && ((c & ~UNIT_MASK) == k); // (R24)
	endfunction
	assign sb_byte = {sb_sr_r[6:0], cmd_s}; // (R18)
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			sb_sr_r <= 8'h00;
			cmd_r <= 8'h00;
			d0_r <= 8'h00;
			d1_r <= 8'h00;
			rep_sr_r <= 8'h00;
			sb_cnt_r <= 3'h0;
			sb_len_r <= 2'h0;
			rep_en_r <= 1'b0;
			rd_stat_r <= 1'b0;
			rd_rx_r <= 1'b0;
		end
		else
		begin
			rd_stat_r <= 1'b0;
			rd_rx_r <= 1'b0;
			if (!cs_act)
			begin
				sb_cnt_r <= 3'h0;
				sb_len_r <= 2'h0;
				rep_en_r <= 1'b0;
			end
			else if (sclk_rise)
			begin
				sb_sr_r <= sb_byte;
				sb_cnt_r <= sb_cnt_r + 3'h1;
				if (rep_en_r)
					rep_sr_r <= {rep_sr_r[6:0], 1'b0}; // (R18)
				if (sb_cnt_r == 3'h7)
				begin
					if (sb_len_r != LEN_MAX)
						sb_len_r <= sb_len_r + 2'h1;
					case (sb_len_r)
						2'h0:
						begin
							cmd_r <= sb_byte;
							// reads take effect at the snapshot so no later event is lost
							if (is_cmd(sb_byte, CMD_STAT, unit_s))
							begin
								rep_sr_r <= stat_r; // (R8)
								rep_en_r <= 1'b1;
								rd_stat_r <= 1'b1;
							end
							else if (is_cmd(sb_byte, CMD_RXRD, unit_s))
							begin
								rep_sr_r <= rx_buf_r;
								rep_en_r <= 1'b1;
								rd_rx_r <= 1'b1;
							end
						end
						2'h1: d0_r <= sb_byte;
						2'h2: d1_r <= sb_byte;
						default: ;
					endcase
				end
			end
		end
	end
	assign reply_data_o = rep_sr_r[7];
	assign reply_oe_o = rep_en_r;
	// writes act when chip select ends, only with all data bytes present
	assign wr_reset = cs_end && (sb_len_r != 2'h0) && (cmd_r == CMD_RESET); // (R23)
	assign wr_ctrl = cs_end && (sb_len_r >= LEN_TWO) && is_cmd(cmd_r, CMD_CTRL, unit_s);
	assign wr_txwr = cs_end && (sb_len_r >= LEN_TWO) && is_cmd(cmd_r, CMD_TXWR, unit_s);
	assign wr_sync = cs_end && (sb_len_r == LEN_MAX) && is_cmd(cmd_r, CMD_SYNC, unit_s);

	//------------------------------------------------------------
	// control and sync word registers
	//------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ctrl_r <= fmf_ctrl_s'(CTRL_RST);
		else if (wr_reset)
			ctrl_r <= fmf_ctrl_s'(CTRL_RST); // (R16)
		else if (wr_ctrl)
			ctrl_r <= fmf_ctrl_s'(d0_r); // (R26)
		else if (ev_sync || ev_inv)
		begin
			ctrl_r.arm_a <= 1'b0; // (R19)
			ctrl_r.arm_b <= 1'b0; // (R19)
		end
	end
	// general reset leaves the sync word alone
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			sync_r <= 16'h0000;
		else if (wr_sync)
			sync_r <= {d0_r, d1_r}; // (R17)
	end

	//------------------------------------------------------------
	// transmit buffer fifo
	//------------------------------------------------------------
	logic fifo_valid;
	logic fifo_ready;
	logic [7:0] fifo_q;
	logic drain_ok;
	logic take;
	fmf_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_txq (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(wr_txwr),
		.in_ready_o(fifo_ready),
		.in_data_i(d0_r),
		.out_valid_o(fifo_valid),
		.out_ready_i(drain_ok),
		.out_data_o(fifo_q)
	);

	//------------------------------------------------------------
	// transmit framer
	//------------------------------------------------------------
	logic [15:0] tx_sr_r;
	logic [4:0] tx_cnt_r;
	logic [2:0] grp_r;
	logic tx_bit_r;
	logic byte_end;
	logic cks_due;
	logic tx_feed;
	logic tx_nbit;
	logic [15:0] cks_w;
	assign byte_end = ((tx_st_r == TX_DATA) || (tx_st_r == TX_CKS)) && (tx_cnt_r == 5'h00);
	assign cks_due = (tx_st_r == TX_DATA) && ctrl_r.cks_en && (grp_r == CKS_GROUP); // (R1)
	assign drain_ok = tx_edge && ((tx_st_r == TX_IDLE) || (byte_end && !cks_due)); // (R20)
	assign take = drain_ok && fifo_valid;
	assign tx_feed = tx_edge && (take || ((tx_st_r == TX_DATA) && !byte_end));
	assign tx_nbit = take ? fifo_q[7] : tx_sr_r[15];
	assign cks_w = {crc_r[14:1], ~crc_r[0], par_r ^ (^crc_r[14:1]) ^ ~crc_r[0]}; // (R1)
	assign ev_want = take; // (R12)
	assign ev_idle = tx_edge && (tx_st_r == TX_HANG); // (R11)
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tx_st_r <= TX_IDLE;
			tx_sr_r <= 16'h0000;
			tx_cnt_r <= 5'h00;
			grp_r <= 3'h0;
			tx_bit_r <= 1'b1;
		end
		else if (!ctrl_r.tx_dir)
		begin
			tx_st_r <= TX_IDLE; // (R20)
			grp_r <= 3'h0;
		end
		else if (tx_edge)
		begin
			if (take)
			begin
				tx_bit_r <= fifo_q[7]; // (R5)
				tx_sr_r <= {fifo_q[6:0], 9'h000};
				tx_cnt_r <= BYTE_BITS_LEFT;
				tx_st_r <= TX_DATA;
				grp_r <= ctrl_r.cks_en ? grp_r + 3'h1 : 3'h0;
			end
			else
				case (tx_st_r)
					TX_IDLE: ;
					TX_DATA, TX_CKS:
					begin
						if (!byte_end)
						begin
							tx_bit_r <= tx_sr_r[15];
							tx_sr_r <= {tx_sr_r[14:0], 1'b0};
							tx_cnt_r <= tx_cnt_r - 5'h01;
						end
						else if (cks_due)
						begin
							tx_bit_r <= cks_w[15]; // (R1)
							tx_sr_r <= {cks_w[14:0], 1'b0};
							tx_cnt_r <= CKS_BITS_LEFT;
							tx_st_r <= TX_CKS;
							grp_r <= 3'h0;
						end
						else
						begin
							tx_bit_r <= 1'b1; // (R22)
							tx_st_r <= TX_HANG;
						end
					end
					TX_HANG: tx_st_r <= TX_IDLE; // (R22)
					default: tx_st_r <= TX_IDLE;
				endcase
		end
	end
	assign tx_bit_o = tx_bit_r;
	assign tx_active_o = ctrl_r.tx_dir && (tx_st_r != TX_IDLE);
	assign tx_bias_o = !tx_active_o; // (R20)

	//------------------------------------------------------------
	// receive framer and sync search
	//------------------------------------------------------------
	logic [2:0] rx_bcnt_r;
	logic [5:0] cks_cnt_r;
	logic framed_r;
	logic free_r;
	logic cks_run;
	assign win_nxt = {win_r[14:0], rxb_s}; // (R5)
	assign ev_sync = rx_edge && armed && (win_nxt == sync_r); // (R6)
	assign ev_inv = rx_edge && armed && (win_nxt == ~sync_r); // (R6)
	assign ev_rx = rx_edge && (rx_bcnt_r == RX_BYTE_LAST) && (framed_r || free_r || !raw_n_s); // (R25)
	assign cks_run = ctrl_r.cks_en && framed_r && !armed; // (R3)
	assign ev_cks = rx_edge && cks_run && (cks_cnt_r == RX_CKS_LAST) && (crc_r == 15'h0000)
		&& (par_r == rxb_s); // (R2)
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			win_r <= 16'h0000;
			rx_bcnt_r <= 3'h0;
			cks_cnt_r <= 6'h00;
			framed_r <= 1'b0;
			free_r <= 1'b0;
			rx_buf_r <= 8'h00;
		end
		else if (ctrl_r.tx_dir)
		begin
			framed_r <= 1'b0;
			free_r <= 1'b0; // (R25)
		end
		else
		begin
			if (armed)
			begin
				framed_r <= 1'b0;
				free_r <= 1'b0; // (R25)
			end
			else if (!raw_n_s)
				free_r <= 1'b1; // (R25)
			if (!cks_run)
				cks_cnt_r <= 6'h00;
			if (rx_edge)
			begin
				win_r <= win_nxt;
				rx_bcnt_r <= rx_bcnt_r + 3'h1;
				if (cks_run)
					cks_cnt_r <= cks_cnt_r + 6'h01; // (R2)
				if (ev_sync || ev_inv)
				begin
					framed_r <= 1'b1; // (R19)
					rx_bcnt_r <= 3'h0;
					cks_cnt_r <= 6'h00;
				end
				if (ev_rx)
					rx_buf_r <= win_nxt[7:0]; // (R5)
			end
		end
	end

	//------------------------------------------------------------
	// checksum divider, shared since only one direction runs
	//------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			crc_r <= 15'h0000;
			par_r <= 1'b0;
		end
		else if (!ctrl_r.cks_en || armed)
		begin
			crc_r <= 15'h0000; // (R3)
			par_r <= 1'b0;
		end
		else if (ctrl_r.tx_dir)
		begin
			if (tx_edge && byte_end && cks_due)
			begin
				crc_r <= 15'h0000;
				par_r <= 1'b0;
			end
			else if (tx_feed)
			begin
				crc_r <= fmf_crc_step(crc_r, tx_nbit); // (R1)
				par_r <= par_r ^ tx_nbit;
			end
		end
		else if (!cks_run || ev_sync || ev_inv)
		begin
			crc_r <= 15'h0000;
			par_r <= 1'b0;
		end
		else if (rx_edge)
		begin
			if (cks_cnt_r == RX_CKS_LAST)
			begin
				crc_r <= 15'h0000;
				par_r <= 1'b0;
			end
			else
			begin
				crc_r <= fmf_crc_step(crc_r, rxb_s ^ (cks_cnt_r == RX_CKS_INV)); // (R2)
				par_r <= par_r ^ rxb_s;
			end
		end
	end

	//------------------------------------------------------------
	// status flags and interrupt
	//------------------------------------------------------------
	logic seen_r;
	logic pend_r;
	logic dir_d_r;
	logic irq_oe_r;
	logic dir_rise;
	logic dir_fall;
	logic rx_clr;
	logic ev_any;
	assign dir_rise = ctrl_r.tx_dir && !dir_d_r;
	assign dir_fall = !ctrl_r.tx_dir && dir_d_r;
	assign rx_clr = (rd_rx_r && seen_r) || dir_rise; // (R13)
	assign ev_any = ev_sync || ev_inv || ev_rx || ev_cks || ev_want || ev_idle;
	// every flag: a set in the clearing cycle wins
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			stat_r <= fmf_stat_s'(STAT_RST);
			seen_r <= 1'b0;
			pend_r <= 1'b0;
			dir_d_r <= 1'b0;
			irq_oe_r <= 1'b0;
		end
		else
		begin
			dir_d_r <= ctrl_r.tx_dir;
			stat_r.sync_hit <= ev_sync || (stat_r.sync_hit && !(rd_stat_r || dir_rise)); // (R10)
			stat_r.inv_hit <= ev_inv || (stat_r.inv_hit && !(rd_stat_r || dir_rise)); // (R10)
			stat_r.cks_ok <= ev_cks || (stat_r.cks_ok && !rx_clr); // (R9)
			stat_r.rx_avail <= ev_rx || (stat_r.rx_avail && !rx_clr); // (R13)
			stat_r.tx_idle <= ev_idle || (stat_r.tx_idle && !(wr_txwr || dir_fall)); // (R11)
			stat_r.tx_want <= ev_want
				|| (stat_r.tx_want && !((wr_txwr && seen_r) || dir_fall)); // (R12)
			seen_r <= rd_stat_r || (seen_r && !(rd_rx_r || wr_txwr));
			pend_r <= ev_any || (pend_r && !(rd_stat_r || dir_rise || dir_fall)); // (R15)
			irq_oe_r <= pend_r && ctrl_r.irq_en; // (R14)
		end
	end
	assign irq_n_o = 1'b0; // (R27)
	assign irq_oe_o = irq_oe_r; // (R27)
endmodule
`default_nettype wire

// [sim/fmf_top_checker.sv]
// checker: port assertions of the modem framing core
`timescale 1ns/1ps
`default_nettype none
module fmf_top_checker (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// watched ports
	input wire logic csn_i,
	input wire logic reply_oe_o,
	input wire logic wake_i,
	input wire logic hold_o,
	input wire logic irq_n_o,
	input wire logic irq_oe_o,
	input wire logic link_clk_i,
	input wire logic tx_bit_o,
	input wire logic tx_active_o,
	input wire logic tx_bias_o
);
	//----------------------------------------
	// properties
	//----------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	bias_inverse_a: assert property (tx_bias_o == !tx_active_o)
		else $error("tx bias is not the inverse of tx active");
	open_drain_a: assert property (irq_n_o == 1'b0)
		else $error("interrupt pin value is not low");
	hold_needs_wake_a: assert property ($rose(hold_o) |-> $past(wake_i, 2))
		else $error("hold entered without wake");
	wake_low_a: assert property (!wake_i [*3] |=> !hold_o)
		else $error("hold kept while wake low");
	reply_in_frame_a: assert property ($rose(reply_oe_o) |-> !csn_i && $past(csn_i, 8) == 1'b0)
		else $error("reply driven outside a frame");
	reply_release_a: assert property ($rose(csn_i) |-> ##[1:6] !reply_oe_o)
		else $error("reply not released after frame end");
	tx_on_bit_edge_a: assert property ($changed(tx_bit_o) |-> link_clk_i)
		else $error("tx bit changed away from a bit clock rise");
	reset_quiet_a: assert property (disable iff (1'b0) !nrst_i |-> !reply_oe_o && !irq_oe_o && tx_bias_o && !hold_o)
		else $error("outputs not quiet in reset");
endmodule
`default_nettype wire

// [sim/fmf_host_model.sv]
// partner: host side of the serial control bus
`timescale 1ns/1ps
`default_nettype none
module fmf_host_model (
	// clock
	input wire logic clk_i,
	// bus lines
	output logic sclk_o,
	output logic csn_o,
	output logic cmd_o,
	input wire logic reply_i,
	input wire logic reply_oe_i
);
	initial
	begin
		sclk_o = 1'b0;
		csn_o = 1'b1;
		cmd_o = 1'b0;
	end
	//----------------------------------------
	// one frame: command then nb bytes
	//----------------------------------------
	// four clocks per sclk phase, above the three the synchroniser needs
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] dat, input int nb,
		output logic [7:0] rd, output logic saw_oe);
		logic [23:0] v;
		v = {cmd, dat};
		rd = 8'h00;
		saw_oe = 1'b0;
		@(posedge clk_i);
		csn_o <= 1'b0;
		for (int i = 0; i < 8 * (nb + 1); i++)
		begin
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
			cmd_o <= v[23 - i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b1;
			saw_oe = saw_oe | reply_oe_i;
			if (i >= 8)
				rd = {rd[6:0], reply_i};
		end
		repeat (4) @(posedge clk_i);
		csn_o <= 1'b1;
		cmd_o <= ~cmd_o;
		repeat (8) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// [sim/fmf_top_tb_top.sv]
// testbench: scenarios for the modem framing core
`timescale 1ns/1ps
`default_nettype none
module fmf_top_tb_top;
	import fmf_pkg::*;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b1;
	logic unit_sel_i = 1'b0;
	logic wake_i = 1'b0;
	logic raw_rx_n_i = 1'b1;
	logic link_clk_i = 1'b0;
	logic rx_bit_i = 1'b0;
	logic lk_en = 1'b0;
	logic sclk_i, csn_i, cmd_data_i, reply_data_o, reply_oe_o, hold_o, irq_n_o, irq_oe_o;
	logic tx_bit_o, tx_active_o, tx_bias_o, oe;
	logic [7:0] rd;
	logic [15:0] cap = 16'h0000;
	int ncap = 0;
	int bad_count = 0;
	int comparisons = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	// bit clock stands still outside frames
	always #80 link_clk_i = lk_en ? ~link_clk_i : 1'b0;
	always @(negedge link_clk_i)
		if (tx_active_o)
		begin
			cap <= {cap[14:0], tx_bit_o};
			ncap <= ncap + 1;
		end
	fmf_top fmf_top_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sclk_i(sclk_i), .csn_i(csn_i),
		.cmd_data_i(cmd_data_i), .reply_data_o(reply_data_o), .reply_oe_o(reply_oe_o),
		.unit_sel_i(unit_sel_i), .wake_i(wake_i), .raw_rx_n_i(raw_rx_n_i), .hold_o(hold_o),
		.irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .link_clk_i(link_clk_i), .rx_bit_i(rx_bit_i),
		.tx_bit_o(tx_bit_o), .tx_active_o(tx_active_o), .tx_bias_o(tx_bias_o));
	fmf_host_model fmf_host_model_i (.clk_i(sys_clk_i), .sclk_o(sclk_i), .csn_o(csn_i),
		.cmd_o(cmd_data_i), .reply_i(reply_data_o), .reply_oe_i(reply_oe_o));
	//----------------------------------------
	// helpers
	//----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input int nb);
		fmf_host_model_i.xfer(c, d, nb, rd, oe);
	endtask
	task automatic rdr(input logic [7:0] c);
		fmf_host_model_i.xfer(c, 16'h0000, 1, rd, oe);
	endtask
	//----------------------------------------
	// scenarios
	//----------------------------------------
	task automatic sc_tx();
		int n;
		n = 0;
		wr(CMD_CTRL, 16'h0100, 1);
		lk_en <= 1'b1;
		wr(CMD_TXWR, 16'hA500, 1);
		while ((ncap < 9 || tx_active_o !== 1'b0) && n < 2000)
		begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n >= 2000)
		begin
			bad_count++;
			report_and_stop();
		end
		lk_en <= 1'b0;
		chk(cap[8:0], 9'h14B);
		chk(irq_oe_o, 1'b0);
		wr(CMD_CTRL, 16'h0900, 1);
		chk(irq_oe_o, 1'b1);
		rdr(CMD_STAT);
		chk(rd, 8'h0C);
		chk(irq_oe_o, 1'b0);
		wr(CMD_TXWR, 16'h5A00, 1);
		rdr(CMD_STAT);
		chk(rd, 8'h00);
	endtask
	task automatic sc_rx(input logic [15:0] w, input logic [7:0] c, input logic [31:0] bits,
		input logic [7:0] st);
		wr(CMD_SYNC, w, 2);
		wr(CMD_CTRL, {c, 8'h00}, 1);
		lk_en <= 1'b1;
		for (int i = 31; i >= 0; i--)
		begin
			@(negedge link_clk_i);
			@(posedge sys_clk_i);
			rx_bit_i <= bits[i];
		end
		@(posedge link_clk_i);
		repeat (8) @(posedge sys_clk_i);
		lk_en <= 1'b0;
		repeat (24) @(posedge sys_clk_i);
		chk(irq_oe_o, 1'b1);
		rdr(CMD_STAT);
		chk(rd, st);
		rdr(CMD_RXRD);
		chk(rd, bits[7:0]);
	endtask
	// strap needs bit 3, general reset passes regardless
	task automatic sc_unit();
		@(posedge sys_clk_i);
		unit_sel_i <= 1'b1;
		wake_i <= 1'b1;
		wr(CMD_CTRL, 16'h0400, 1);
		chk(hold_o, 1'b0);
		wake_i <= 1'b0;
		wr(CMD_CTRL | UNIT_MASK, 16'h0400, 1);
		chk(hold_o, 1'b0);
		wake_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		chk(hold_o, 1'b1);
		rdr(CMD_STAT);
		chk(oe, 1'b0);
		rdr(CMD_STAT | UNIT_MASK);
		chk(oe, 1'b1);
		wr(CMD_RESET, 16'h0000, 0);
		chk(hold_o, 1'b0);
		chk(tx_bias_o, 1'b1);
		rdr(CMD_RXRD | UNIT_MASK);
		chk(rd, 8'hC3);
		unit_sel_i <= 1'b0;
		wake_i <= 1'b0;
	endtask
	initial
	begin
		// a real falling edge, so the async reset clears state before the first clock
		nrst_i <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		sc_tx();
		sc_rx(16'hF00F, 8'h28, 32'hAAF00F3C, 8'h21);
		sc_rx(16'hF00F, 8'h48, 32'hAA0FF0C3, 8'h11);
		sc_unit();
		report_and_stop();
	end
endmodule
bind fmf_top fmf_top_checker fmf_top_checker_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
	.csn_i(csn_i), .reply_oe_o(reply_oe_o), .wake_i(wake_i), .hold_o(hold_o),
	.irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .link_clk_i(link_clk_i), .tx_bit_o(tx_bit_o),
	.tx_active_o(tx_active_o), .tx_bias_o(tx_bias_o));
`default_nettype wire
